// File: hdl/uart_modem_ctl_line_status.sv
// Modem-control outputs and upper line-status flags, AXI4-Lite slave
`timescale 1ns/1ns
`include "uart_mcl_defs.svh"
module uart_modem_ctl_line_status
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	// AXI4-Lite slave
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Modem pins, all active low
	output logic             rts_n,
	output logic             dtr_n,
	output logic             out2_n,
	input  wire logic        cts_n,
	input  wire logic        dsr_n,
	input  wire logic        cd_n,
	input  wire logic        ri_n,
	// Modem status and mode bits seen by the rest of the channel, active high
	output logic             cts_seen,
	output logic             dsr_seen,
	output logic             cd_seen,
	output logic             ri_seen,
	output logic             loopback,
	output logic             ir_mode,
	// Receive FIFO activity
	input  wire logic        fifo_mode,
	input  wire logic        rx_push,
	input  wire logic        rx_push_err,
	input  wire logic        rx_pop,
	input  wire logic        rx_clear,
	// Transmit side occupancy
	input  wire logic        tx_hold_empty,
	input  wire logic        tx_fifo_empty,
	input  wire logic        tx_shift_empty,
	output logic             irq
);
	// ==========================================================
	// State
	uart_mcl_pkg::byte_t       modem_control_reg;
	logic [1:0]                int_status;
	logic [1:0]                int_enable;
	logic                      tx_empty;
	logic                      rx_err_flag;
	logic [`MCL_RX_AW-1:0]     rx_wptr;
	logic [`MCL_RX_AW-1:0]     rx_rptr;
	logic [`MCL_RX_AW:0]       err_count;
	logic                      head_err;
	logic                      aw_held;
	logic                      w_held;
	uart_mcl_pkg::ofs_t        aw_addr;
	logic [7:0]                w_data;
	logic                      w_lane0;
	logic                      b_pend;
	logic                      r_pend;

	// ==========================================================
	// Modem outputs and loop-back routing
	wire lb = modem_control_reg[`MCL_MC_LOOP];

	// In loop-back the pins go inactive; the bits feed the status side
	assign rts_n    = lb | ~modem_control_reg[`MCL_MC_RTS];
	assign dtr_n    = lb | ~modem_control_reg[`MCL_MC_DTR];
	assign out2_n   = lb | ~modem_control_reg[`MCL_MC_OUT2];
	assign cts_seen = lb ? modem_control_reg[`MCL_MC_RTS]
	                     : ~cts_n;
	assign dsr_seen = lb ? modem_control_reg[`MCL_MC_DTR]
	                     : ~dsr_n;
	assign cd_seen  = lb ? modem_control_reg[`MCL_MC_OUT2]
	                     : ~cd_n;
	// The spare bit has no pin of its own and matters only in loop-back
	assign ri_seen  = lb ? modem_control_reg[`MCL_MC_SPARE]
	                     : ~ri_n;
	assign loopback = lb;
	assign ir_mode  = modem_control_reg[`MCL_MC_IR];

	// ==========================================================
	// Receive error tracking
	wire                  push_err = rx_push & rx_push_err;
	wire                  pop_err  = rx_pop & head_err;
	wire [`MCL_RX_AW-1:0] next_rptr = rx_clear ? '0
	                                 : rx_rptr + {3'h0, rx_pop};
	wire [`MCL_RX_AW:0]   next_err_count = err_count
	                                 + {4'h0, push_err}
	                                 - {4'h0, pop_err};

	// Read address runs one step ahead so the head mark is ready at a pop
	err_flag_mem u_err_mem
	(
		.clk   (clk),
		.nrst  (nrst),
		.ce    (ce),
		.we    (rx_push),
		.waddr (rx_wptr),
		.wdata (rx_push_err),
		.raddr (next_rptr),
		.rdata (head_err)
	);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_wptr   <= '0;
			rx_rptr   <= '0;
			err_count <= '0;
		end
		else if (ce)
		begin
			rx_wptr   <= rx_clear ? '0 : rx_wptr + {3'h0, rx_push};
			rx_rptr   <= next_rptr;
			// Counts marked characters still queued
			err_count <= rx_clear ? '0 : next_err_count;
		end
	end

	// A push in the cycle of rx_clear is lost along with the queue
	assign rx_err_flag = (err_count != '0);

	// ==========================================================
	// Transmitter empty flag
	// Registered so the interrupt edge sees a clean, settled level
	wire hold_side_empty = fifo_mode ? tx_fifo_empty : tx_hold_empty;
	wire next_tx_empty   = hold_side_empty & tx_shift_empty;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			tx_empty <= 1'b1;
		else if (ce)
			tx_empty <= next_tx_empty;
	end

	// ==========================================================
	// Interrupts: rising edges of the two flags are the events
	logic tx_empty_d;
	logic rx_err_d;
	wire [1:0] ev;
	assign ev[`MCL_IS_TX_EMPTY] = tx_empty & ~tx_empty_d;
	assign ev[`MCL_IS_RX_ERR]   = rx_err_flag & ~rx_err_d;

	// ==========================================================
	// AXI4-Lite write path: address and data taken in either order
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take  = s_axi_wvalid & s_axi_wready;
	wire do_wr   = aw_held & w_held & ~b_pend;

	// Gated by ce so a frozen block never completes a handshake
	assign s_axi_awready = ce & ~aw_held & ~b_pend;
	assign s_axi_wready  = ce & ~w_held & ~b_pend;
	assign s_axi_bvalid  = ce & b_pend;

	wire wr_mc   = do_wr & w_lane0 & (aw_addr == `MCL_OFS_MODEM_CONTROL);
	wire wr_ie   = do_wr & w_lane0 & (aw_addr == `MCL_OFS_INT_ENABLE);
	wire wr_ic   = do_wr & w_lane0 & (aw_addr == `MCL_OFS_INT_CLEAR);
	// Line status and interrupt status accept the write but keep their value
	wire wr_ok   = (aw_addr == `MCL_OFS_MODEM_CONTROL)
	             | (aw_addr == `MCL_OFS_LINE_STATUS)
	             | (aw_addr == `MCL_OFS_INT_STATUS)
	             | (aw_addr == `MCL_OFS_INT_CLEAR)
	             | (aw_addr == `MCL_OFS_INT_ENABLE);
	wire [1:0] clr_bits = wr_ic ? w_data[1:0] : 2'h0;
	// Set wins over a clear in the same cycle
	wire [1:0] next_int_status = (int_status & ~clr_bits) | ev;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= 8'h00;
			w_lane0 <= 1'b0;
		end
		else if (ce)
		begin
			if (aw_take)
			begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[4:2], 2'h0};
			end
			else if (do_wr)
				aw_held <= 1'b0;
			if (w_take)
			begin
				w_held  <= 1'b1;
				w_data  <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end
			else if (do_wr)
				w_held <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			b_pend       <= 1'b0;
			s_axi_bresp  <= uart_mcl_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (do_wr)
			begin
				b_pend       <= 1'b1;
				s_axi_bresp  <= wr_ok ? uart_mcl_pkg::RESP_OKAY
				                      : uart_mcl_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
				b_pend <= 1'b0;
		end
	end

	// ==========================================================
	// Register storage
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			modem_control_reg <= `MCL_MC_RESET;
			int_enable        <= 2'h0;
			int_status        <= `MCL_IS_RESET;
			tx_empty_d        <= 1'b1;
			rx_err_d          <= 1'b0;
		end
		else if (ce)
		begin
			if (wr_mc)
				modem_control_reg <= w_data & `MCL_MC_WMASK;
			if (wr_ie)
				int_enable <= w_data[1:0];
			int_status <= next_int_status;
			tx_empty_d <= tx_empty;
			rx_err_d   <= rx_err_flag;
		end
	end

	assign irq = |(int_status & int_enable);

	// ==========================================================
	// AXI4-Lite read path
	uart_mcl_pkg::ofs_t ra;
	assign ra = {s_axi_araddr[4:2], 2'h0};

	wire [7:0] line_status_reg = {rx_err_flag, tx_empty, 6'h00};
	wire       rd_hit_mc = (ra == `MCL_OFS_MODEM_CONTROL);
	wire       rd_hit_ls = (ra == `MCL_OFS_LINE_STATUS);
	wire       rd_hit_is = (ra == `MCL_OFS_INT_STATUS);
	wire       rd_hit_ic = (ra == `MCL_OFS_INT_CLEAR);
	wire       rd_hit_ie = (ra == `MCL_OFS_INT_ENABLE);
	wire [7:0] rd_val    = rd_hit_mc ? modem_control_reg
	                     : rd_hit_ls ? line_status_reg
	                     : rd_hit_is ? {6'h00, int_status}
	                     : rd_hit_ie ? {6'h00, int_enable}
	                     : 8'h00;
	wire       rd_ok     = rd_hit_mc | rd_hit_ls | rd_hit_is
	                     | rd_hit_ic | rd_hit_ie;
	wire       ar_take   = s_axi_arvalid & s_axi_arready;

	assign s_axi_arready = ce & ~r_pend;
	assign s_axi_rvalid  = ce & r_pend;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			r_pend       <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= uart_mcl_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (ar_take)
			begin
				r_pend       <= 1'b1;
				s_axi_rdata  <= {24'h000000, rd_val};
				s_axi_rresp  <= rd_ok ? uart_mcl_pkg::RESP_OKAY
				                      : uart_mcl_pkg::RESP_SLVERR;
			end
			else if (s_axi_rready)
				r_pend <= 1'b0;
		end
	end
endmodule : uart_modem_ctl_line_status

// File: hdl/uart_mcl_defs.svh
// Constants for the modem-control and line-status block
//
// Operation
// - Spare output bit never reaches a pin
// - Spare bit drives ring indicator in loop-back
// - RTS bit 0 holds rts_n high
// - RTS bit 1 drives rts_n low
// - dtr_n is inverse of DTR bit
// - Error flag set while errored character held
// - Error flag clears when no errored characters
// - Error flag reads 0 after reset
// - Non-FIFO: empty when holding and shift empty
// - Empty flag 0 while any character held
// - FIFO mode: empty when FIFO, shift empty
// - Loop-back disconnects pins, routes modem bits internally
`ifndef UART_MCL_DEFS_SVH
`define UART_MCL_DEFS_SVH

// ==========================================================
// Register byte offsets
`define MCL_OFS_MODEM_CONTROL 5'h00
`define MCL_OFS_LINE_STATUS   5'h04
`define MCL_OFS_INT_STATUS    5'h08
`define MCL_OFS_INT_CLEAR     5'h0c
`define MCL_OFS_INT_ENABLE    5'h10

// ==========================================================
// Modem-control fields
`define MCL_MC_DTR       0
`define MCL_MC_RTS       1
`define MCL_MC_SPARE     2
`define MCL_MC_OUT2      3
`define MCL_MC_LOOP      4
`define MCL_MC_IR        6
`define MCL_MC_WMASK     8'h5f
`define MCL_MC_RESET     8'h00

// ==========================================================
// Line-status fields
`define MCL_LS_TX_EMPTY  6
`define MCL_LS_RX_ERR    7

// ==========================================================
// Interrupt status bits
`define MCL_IS_TX_EMPTY  0
`define MCL_IS_RX_ERR    1
`define MCL_IS_RESET     2'h0

// ==========================================================
// Receive FIFO shape
`define MCL_RX_DEPTH     16
`define MCL_RX_AW        4

`endif

// File: hdl/uart_mcl_pkg.sv
// Types shared by the modem-control and line-status block
package uart_mcl_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [1:0]  resp_t;
	typedef logic [4:0]  ofs_t;
	localparam resp_t RESP_OKAY   = 2'h0;
	localparam resp_t RESP_SLVERR = 2'h2;
endpackage : uart_mcl_pkg

// File: hdl/err_flag_mem.sv
// Per-entry error marks of the receive FIFO, registered read
`timescale 1ns/1ns
`include "uart_mcl_defs.svh"
module err_flag_mem
(
	input  wire logic                    clk,
	input  wire logic                    nrst,
	input  wire logic                    ce,
	input  wire logic                    we,
	input  wire logic [`MCL_RX_AW-1:0]   waddr,
	input  wire logic                    wdata,
	input  wire logic [`MCL_RX_AW-1:0]   raddr,
	output logic                         rdata
);
	logic [`MCL_RX_DEPTH-1:0] mem;
	wire                      bypass = we && (waddr == raddr);

	always_ff @(posedge clk)
	begin
		if (ce && we)
			mem[waddr] <= wdata;
	end

	// Write-through keeps the head mark correct when pushing into empty
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rdata <= 1'b0;
		else if (ce)
			rdata <= bypass ? wdata : mem[raddr];
	end
endmodule : err_flag_mem

// File: verification/mcl_sva.sv
// Port-level assertion checker for the modem-control and line-status block
`timescale 1ns/1ns
module mcl_sva
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic rts_n,
	input wire logic dtr_n,
	input wire logic out2_n,
	input wire logic loopback,
	input wire logic ri_seen,
	input wire logic ri_n,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ==========================================================
	// Modem outputs
	property p_loop_pins; loopback |-> rts_n && dtr_n && out2_n; endproperty
	a_loop_pins: assert property (p_loop_pins) else $error("pins live");
	property p_ri_pin; !loopback |-> ri_seen == !ri_n; endproperty
	a_ri_pin: assert property (p_ri_pin) else $error("ri not pin");
	// Outputs follow the register, so they move only as a write completes
	property p_rts_chg; $changed(rts_n) |-> $rose(s_axi_bvalid); endproperty
	a_rts_chg: assert property (p_rts_chg) else $error("rts moved");
	property p_dtr_chg; $changed(dtr_n) |-> $rose(s_axi_bvalid); endproperty
	a_dtr_chg: assert property (p_dtr_chg) else $error("dtr moved");
	// ==========================================================
	// Register bus
	// The register write takes one cycle before the response rises
	property p_wr_resp;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> ##1 s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("no bvalid");
	property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("no rvalid");
	property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_ar_block: assert property (p_ar_block) else $error("ar while r");
	property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_once: assert property (p_b_once) else $error("b repeated");
	c_loop: cover property (loopback);
	c_irq: cover property ($rose(irq));
	c_read: cover property (s_axi_rvalid);
endmodule : mcl_sva
bind uart_modem_ctl_line_status mcl_sva u_sva (.clk, .nrst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .rts_n,
	.dtr_n, .out2_n, .loopback, .ri_seen, .ri_n, .irq);

// File: verification/axi_host.sv
// AXI4-Lite host model that stands in for the CPU
`timescale 1ns/1ns
module axi_host
(
	input  wire logic        clk,
	output logic [4:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic        s_axi_bvalid,
	input  wire logic [1:0]  s_axi_bresp,
	output logic             s_axi_bready,
	output logic [4:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic        s_axi_rvalid,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	output logic             s_axi_rready
);
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
	end
	// Released payloads are inverted so stale values are never trusted
	task automatic wr(input logic [4:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready)
				{s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
			if (s_axi_wvalid && s_axi_wready)
				{s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
		end
		while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready)
				{s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
		end
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
endmodule : axi_host

// File: verification/uart_modem_ctl_line_status_test.sv
// Self-checking testbench for the modem-control and line-status block
`timescale 1ns/1ns
module uart_modem_ctl_line_status_test;
	logic        clk, nrst, cts_n, ri_n, fifo_mode, hold_e, fifo_e, shift_e;
	logic        rx_push, rx_push_err, rx_pop, rx_clear;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, rts_n, dtr_n, irq;
	logic        cts_seen, ri_seen, loopback, ce, out2_n, dsr_seen, cd_seen;
	logic        ir_mode;
	logic [4:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [7:0]  v;
	int          error_cnt, checks, i;
	axi_host host (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
		.s_axi_bresp, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rready);
	uart_modem_ctl_line_status dut (.clk, .nrst, .ce, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rts_n,
		.dtr_n, .out2_n, .cts_n, .dsr_n(ri_n), .cd_n(cts_n), .ri_n,
		.cts_seen, .dsr_seen, .cd_seen, .ri_seen, .loopback, .ir_mode,
		.fifo_mode, .rx_push, .rx_push_err, .rx_pop, .rx_clear,
		.tx_hold_empty(hold_e), .tx_fifo_empty(fifo_e),
		.tx_shift_empty(shift_e), .irq);
	always #10 clk = ~clk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task rdchk(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] er);
		host.rd(a, d, r);
		chk(d, exp);
		chk({30'h0, r}, {30'h0, er});
	endtask : rdchk
	// Expected line status from the levels the bench holds right now
	function logic [31:0] ls(input logic err);
		ls = {24'h0, err, shift_e & (fifo_mode ? fifo_e : hold_e), 6'h0};
	endfunction : ls
	task rdls(input logic err);
		host.rd(5'h04, d, r);
		chk(d, ls(err));
	endtask : rdls
	task ev(input logic [2:0] m, input logic e);
		@(posedge clk);
		{rx_push, rx_pop, rx_clear, rx_push_err} <= {m, e};
		@(posedge clk);
		{rx_push, rx_pop, rx_clear} <= 3'h0;
	endtask : ev
	task end_of_test;
		if (error_cnt == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	initial
	begin
		#200000;
		error_cnt++;
		end_of_test;
	end
	initial
	begin
		{clk, nrst, fifo_mode, rx_push, rx_push_err, rx_pop, rx_clear} = 7'h0;
		{cts_n, ri_n, hold_e, fifo_e, shift_e} = 5'h1f;
		ce = 1'b1;
		void'($urandom(32'hba50e0ab));
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		chk(rts_n, 1'b1);
		chk(dtr_n, 1'b1);
		rdls(1'b0);
		for (i = 0; i < 12; i++)
		begin
			v = (i == 0) ? 8'hff : (i == 1) ? 8'h14 : (i == 2) ? 8'h03
				: 8'($urandom);
			host.wr(5'h00, {24'h0, v}, r);
			d = $urandom;
			{cts_n, ri_n} <= d[1:0];
			rdchk(5'h00, {24'h0, v & 8'h5f}, 2'h0);
			chk(rts_n, !v[1] || v[4]);
			chk(dtr_n, !v[0] || v[4]);
			chk(ri_seen, v[4] ? v[2] : !ri_n);
			chk(cts_seen, v[4] ? v[1] : !cts_n);
			chk(dsr_seen, v[4] ? v[0] : !ri_n);
			chk(cd_seen, v[4] ? v[3] : !cts_n);
			chk(out2_n, !v[3] || v[4]);
			chk(loopback, v[4]);
			chk(ir_mode, v[6]);
		end
		host.wr(5'h00, 32'h0, r);
		for (i = 0; i < 16; i++)
		begin
			{fifo_mode, hold_e, fifo_e, shift_e} <= i[3:0];
			rdls(1'b0);
		end
		host.wr(5'h04, 32'hff, r);
		chk({30'h0, r}, 32'h0);
		rdls(1'b0);
		ev(3'h1, 1'b0);
		ev(3'h4, 1'b1);
		ev(3'h4, 1'b0);
		rdls(1'b1);
		ev(3'h2, 1'b0);
		rdls(1'b0);
		// A push while ce is low must leave the error count alone
		ce <= 1'b0;
		ev(3'h4, 1'b1);
		ce <= 1'b1;
		rdls(1'b0);
		ev(3'h4, 1'b1);
		ev(3'h2, 1'b0);
		rdls(1'b1);
		ev(3'h2, 1'b0);
		rdls(1'b0);
		host.wr(5'h0c, 32'h3, r);
		host.wr(5'h10, 32'h2, r);
		ev(3'h4, 1'b1);
		rdchk(5'h08, 32'h2, 2'h0);
		chk(irq, 1'b1);
		host.wr(5'h10, 32'h0, r);
		chk(irq, 1'b0);
		host.wr(5'h10, 32'h2, r);
		host.wr(5'h0c, 32'h2, r);
		chk(irq, 1'b0);
		rdchk(5'h0c, 32'h0, 2'h0);
		rdchk(5'h14, 32'h0, 2'h2);
		host.wr(5'h1c, 32'h1, r);
		chk({30'h0, r}, 32'h2);
		end_of_test;
	end
endmodule : uart_modem_ctl_line_status_test
